/* File: design/xcv_params.svh */
/*
  Constants of the transceiver serial register port: register addresses,
  storage indices, reset values, field masks, status bit positions,
  power state codes and frame bit counts.
  Assumes it is included by its bare name from the design files.
*/
`ifndef XCV_PARAMS_SVH
`define XCV_PARAMS_SVH

// register addresses, 7 bit
`define XCV_ADDR_SILICON_REVISION 7'h00
`define XCV_ADDR_SCRATCH_PROBE 7'h01
`define XCV_ADDR_POWER_MODE_CONTROL 7'h02
`define XCV_ADDR_OSCILLATOR_GAIN 7'h03
`define XCV_ADDR_QUEUE_CONTROL_STATUS 7'h04
`define XCV_ADDR_QUEUE_DATA_PORT 7'h05
`define XCV_ADDR_IRQ_ENABLE_MASK 7'h06
`define XCV_ADDR_IRQ_PENDING 7'h07
`define XCV_ADDR_HOST_PORT_MODE 7'h08
`define XCV_ADDR_PIN_CONFIG_ONE 7'h0C
`define XCV_ADDR_PIN_CONFIG_TWO 7'h0D
`define XCV_ADDR_PIN_READBACK 7'h0E
`define XCV_ADDR_IRQ_POLARITY 7'h0F
`define XCV_ADDR_MODULATION_SELECT 7'h10
`define XCV_ADDR_LINE_CODING_SELECT 7'h11
`define XCV_ADDR_FRAME_SETTINGS 7'h12
`define XCV_ADDR_CHECK_SEED_BYTE3 7'h14
`define XCV_ADDR_CHECK_SEED_BYTE2 7'h15
`define XCV_ADDR_CHECK_SEED_BYTE1 7'h16
`define XCV_ADDR_CHECK_SEED_BYTE0 7'h17
`define XCV_ADDR_REGULATOR_STATUS 7'h1B

// storage indices of the writable registers
`define XCV_NUM_STORE 16
`define XCV_IDX_SCRATCH 4'h0
`define XCV_IDX_POWER 4'h1
`define XCV_IDX_OSC 4'h2
`define XCV_IDX_QCTL 4'h3
`define XCV_IDX_IRQ_MASK 4'h4
`define XCV_IDX_HOST_MODE 4'h5
`define XCV_IDX_PIN_ONE 4'h6
`define XCV_IDX_PIN_TWO 4'h7
`define XCV_IDX_IRQ_POL 4'h8
`define XCV_IDX_MODULATION 4'h9
`define XCV_IDX_CODING 4'hA
`define XCV_IDX_FRAME 4'hB
`define XCV_IDX_SEED3 4'hC
`define XCV_IDX_SEED2 4'hD
`define XCV_IDX_SEED1 4'hE
`define XCV_IDX_SEED0 4'hF

// reset values
`define XCV_RST_SCRATCH 8'hC5
`define XCV_RST_POWER 8'h00
`define XCV_RST_OSC 8'h02
`define XCV_RST_QCTL 8'h03
`define XCV_RST_IRQ_MASK 8'h00
`define XCV_RST_HOST_MODE 8'h03
`define XCV_RST_PIN_ONE 8'hF8
`define XCV_RST_PIN_TWO 8'h00
`define XCV_RST_IRQ_POL 8'h00
`define XCV_RST_MODULATION 8'h02
`define XCV_RST_CODING 8'h02
`define XCV_RST_FRAME 8'h00
`define XCV_RST_SEED 8'hFF

// implemented bits of each register
`define XCV_MASK_FULL 8'hFF
`define XCV_MASK_NIBBLE 8'h0F
`define XCV_MASK_SIX 8'h3F
`define XCV_MASK_SEVEN 8'h7F
`define XCV_MASK_QCMD 8'h03
`define XCV_MASK_NONE 8'h00

// power control byte fields
`define XCV_SOFT_RESET_BIT 7
`define XCV_POWER_STATE_FIELD_MSB 3

// power state codes
`define XCV_DEEP_SLEEP_STATE 4'h0
`define XCV_REGULATOR_ON_STATE 4'h4
`define XCV_STANDBY_STATE 4'h5
`define XCV_RX_SYNTH_SETTLE_STATE 4'h8
`define XCV_RX_ACTIVE_STATE 4'h9
`define XCV_TX_SYNTH_SETTLE_STATE 4'hC
`define XCV_TX_ACTIVE_STATE 4'hD

// read status word positions
`define XCV_ST_LOCK 6
`define XCV_ST_OVER 5
`define XCV_ST_UNDER 4
`define XCV_ST_FULL 3
`define XCV_ST_EMPTY 2
`define XCV_ST_CODE_MSB 1

// frame bit counts, counter after n rising edges holds n
`define XCV_CNT_ZERO 5'h00
`define XCV_CNT_ONE 5'h01
`define XCV_CNT_HDR_LAST 5'h07
`define XCV_CNT_DATA_LOAD 5'h08
`define XCV_CNT_FRAME_LAST 5'h0F
`define XCV_CNT_FRAME_BITS 5'h10

// host side waits, for reference of the driving software
`define XCV_XTAL_SETTLE_NS 3000000
`define XCV_SYNTH_SETTLE_MIN_NS 5000
`define XCV_SYNTH_SETTLE_MAX_NS 50000
`define XCV_MCLK_PERIOD_NS 5
`define XCV_XTAL_SETTLE_CYC (`XCV_XTAL_SETTLE_NS / `XCV_MCLK_PERIOD_NS)

`endif

/* File: design/xcv_pkg.sv */
/*
  Types shared by the transceiver serial register port.
  Assumes xcv_params.svh supplies the numeric constants.
*/
package xcv_pkg;
    typedef logic [7:0] xcv_byte_t;
    typedef logic [6:0] xcv_addr_t;
    typedef logic [3:0] xcv_idx_t;
    typedef logic [4:0] xcv_bitcnt_t;
endpackage : xcv_pkg

/* File: design/xcv_spi_regs.sv */
/*
  Serial register port of the transceiver: a four wire serial slave on its
  own clock, the control register file on the main clock, and the power
  state stepping guard.
  Assumes sclk_i is idle low with sel_b_i high between frames, and that
  sclk_i runs no faster than one eighth of mclk_i; status and device inputs
  are synchronous to mclk_i.
*/
// Notes on behaviour
// - register access works in every power state, sleep included.
// - select low opens a 16 bit frame on the serial input.
// - address and direction decoded; 1 writes the byte, 0 reads it.
// - read frames shift seven status bits, then eight data bits.
// - status order lock, over, under, full, empty, two bit state code.
// - written values stored unchecked; bit 0 is the least significant.
// - power field codes 0,4,5,8,9,C,D for the seven states.
`timescale 1ns/100ps
`default_nettype none
`include "xcv_params.svh"

// two stage level synchroniser onto the main clock
module xcv_sync2
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic rst_val_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_reg;

    // only the second stage is ever read
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            meta_reg <= rst_val_i;
            q_o <= rst_val_i;
        end
        else
        begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule : xcv_sync2

module xcv_spi_regs
#(
    parameter logic [7:0] SILICON_ID = 8'h5A // arbitrary value
)
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic sel_b_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic synth_lock_i,
    input wire logic queue_over_i,
    input wire logic queue_under_i,
    input wire logic queue_full_i,
    input wire logic queue_empty_i,
    input wire logic [1:0] queue_state_code_i,
    input wire logic [7:0] queue_rdata_i,
    input wire logic [5:0] irq_pending_i,
    input wire logic [7:0] pin_readback_i,
    input wire logic [3:0] regulator_status_i,
    output logic [3:0] power_state_o,
    output logic soft_reset_o,
    output logic [3:0] osc_gain_o,
    output logic [1:0] queue_cmd_o,
    output logic queue_cmd_stb_o,
    output logic queue_push_o,
    output logic [7:0] queue_wdata_o,
    output logic queue_pop_o,
    output logic [5:0] irq_mask_o,
    output logic [5:0] irq_invert_o,
    output logic [3:0] host_mode_o,
    output logic [7:0] pin_cfg_one_o,
    output logic [7:0] pin_cfg_two_o,
    output logic [6:0] modulation_o,
    output logic [3:0] line_coding_o,
    output logic [7:0] frame_cfg_o,
    output logic [31:0] check_seed_o
);
    // serial clock domain
    xcv_pkg::xcv_bitcnt_t bit_cnt_reg;
    xcv_pkg::xcv_byte_t in_sh_reg;
    xcv_pkg::xcv_byte_t hdr_reg;
    xcv_pkg::xcv_byte_t dat_reg;
    logic hdr_ready_reg;
    logic frame_done_reg;
    logic [6:0] out_sh_reg;
    // main clock domain
    logic sel_idle_s;
    logic hdr_ready_s;
    logic frame_done_s;
    logic hdr_ready_d_reg;
    logic frame_done_d_reg;
    logic [6:0] status_hold_reg;
    xcv_pkg::xcv_byte_t rd_word_reg;
    xcv_pkg::xcv_byte_t store_reg [`XCV_NUM_STORE];
    logic [3:0] eff_power_reg;
    logic hdr_take;
    logic frame_take;
    logic is_write;
    xcv_pkg::xcv_addr_t cur_addr;
    logic wr_hit;
    xcv_pkg::xcv_idx_t wr_idx;
    logic [3:0] req_power;

    // reset value of each storage index
    function automatic xcv_pkg::xcv_byte_t reset_of(input xcv_pkg::xcv_idx_t idx);
        case (idx)
            `XCV_IDX_SCRATCH: reset_of = `XCV_RST_SCRATCH;
            `XCV_IDX_POWER: reset_of = `XCV_RST_POWER;
            `XCV_IDX_OSC: reset_of = `XCV_RST_OSC;
            `XCV_IDX_QCTL: reset_of = `XCV_RST_QCTL;
            `XCV_IDX_IRQ_MASK: reset_of = `XCV_RST_IRQ_MASK;
            `XCV_IDX_HOST_MODE: reset_of = `XCV_RST_HOST_MODE;
            `XCV_IDX_PIN_ONE: reset_of = `XCV_RST_PIN_ONE;
            `XCV_IDX_PIN_TWO: reset_of = `XCV_RST_PIN_TWO;
            `XCV_IDX_IRQ_POL: reset_of = `XCV_RST_IRQ_POL;
            `XCV_IDX_MODULATION: reset_of = `XCV_RST_MODULATION;
            `XCV_IDX_CODING: reset_of = `XCV_RST_CODING;
            `XCV_IDX_FRAME: reset_of = `XCV_RST_FRAME;
            default: reset_of = `XCV_RST_SEED;
        endcase
    endfunction : reset_of

    // implemented bits; unimplemented ones read back as zero
    function automatic xcv_pkg::xcv_byte_t mask_of(input xcv_pkg::xcv_idx_t idx);
        case (idx)
            `XCV_IDX_POWER, `XCV_IDX_OSC, `XCV_IDX_HOST_MODE, `XCV_IDX_CODING:
                mask_of = `XCV_MASK_NIBBLE; // soft reset bit is never stored
            `XCV_IDX_QCTL: mask_of = `XCV_MASK_QCMD;
            `XCV_IDX_IRQ_MASK, `XCV_IDX_IRQ_POL: mask_of = `XCV_MASK_SIX;
            `XCV_IDX_MODULATION: mask_of = `XCV_MASK_SEVEN;
            default: mask_of = `XCV_MASK_FULL;
        endcase
    endfunction : mask_of

    // address to storage index; miss for read-only and unmapped addresses
    function automatic logic [4:0] index_of(input xcv_pkg::xcv_addr_t a);
        case (a)
            `XCV_ADDR_SCRATCH_PROBE: index_of = {1'b1, `XCV_IDX_SCRATCH};
            `XCV_ADDR_POWER_MODE_CONTROL: index_of = {1'b1, `XCV_IDX_POWER};
            `XCV_ADDR_OSCILLATOR_GAIN: index_of = {1'b1, `XCV_IDX_OSC};
            `XCV_ADDR_QUEUE_CONTROL_STATUS: index_of = {1'b1, `XCV_IDX_QCTL};
            `XCV_ADDR_IRQ_ENABLE_MASK: index_of = {1'b1, `XCV_IDX_IRQ_MASK};
            `XCV_ADDR_HOST_PORT_MODE: index_of = {1'b1, `XCV_IDX_HOST_MODE};
            `XCV_ADDR_PIN_CONFIG_ONE: index_of = {1'b1, `XCV_IDX_PIN_ONE};
            `XCV_ADDR_PIN_CONFIG_TWO: index_of = {1'b1, `XCV_IDX_PIN_TWO};
            `XCV_ADDR_IRQ_POLARITY: index_of = {1'b1, `XCV_IDX_IRQ_POL};
            `XCV_ADDR_MODULATION_SELECT: index_of = {1'b1, `XCV_IDX_MODULATION};
            `XCV_ADDR_LINE_CODING_SELECT: index_of = {1'b1, `XCV_IDX_CODING};
            `XCV_ADDR_FRAME_SETTINGS: index_of = {1'b1, `XCV_IDX_FRAME};
            `XCV_ADDR_CHECK_SEED_BYTE3: index_of = {1'b1, `XCV_IDX_SEED3};
            `XCV_ADDR_CHECK_SEED_BYTE2: index_of = {1'b1, `XCV_IDX_SEED2};
            `XCV_ADDR_CHECK_SEED_BYTE1: index_of = {1'b1, `XCV_IDX_SEED1};
            `XCV_ADDR_CHECK_SEED_BYTE0: index_of = {1'b1, `XCV_IDX_SEED0};
            default: index_of = {1'b0, `XCV_IDX_SCRATCH};
        endcase
    endfunction : index_of

    // frame bit counter; select high clears it and drops any partial frame
    always_ff @(posedge sclk_i or posedge sel_b_i)
    begin
        if (sel_b_i)
            bit_cnt_reg <= `XCV_CNT_ZERO;
        else if (bit_cnt_reg != `XCV_CNT_FRAME_BITS)
            bit_cnt_reg <= bit_cnt_reg + `XCV_CNT_ONE; // bits past 16 ignored
    end

    // input shifter, msb first, sampled on the rising edge
    always_ff @(posedge sclk_i or posedge sel_b_i)
    begin
        if (sel_b_i)
            in_sh_reg <= 8'h00;
        else if (bit_cnt_reg != `XCV_CNT_FRAME_BITS)
            in_sh_reg <= {in_sh_reg[6:0], mosi_i};
    end

    // header and data bytes survive select high so the main clock can take them
    always_ff @(posedge sclk_i)
    begin
        if (bit_cnt_reg == `XCV_CNT_HDR_LAST)
            hdr_reg <= {in_sh_reg[6:0], mosi_i}; // direction then address
        if (bit_cnt_reg == `XCV_CNT_FRAME_LAST)
            dat_reg <= {in_sh_reg[6:0], mosi_i};
    end

    // level flags toward the main clock, ended by the frame's own select
    always_ff @(posedge sclk_i or posedge sel_b_i)
    begin
        if (sel_b_i)
        begin
            hdr_ready_reg <= 1'b0;
            frame_done_reg <= 1'b0;
        end
        else
        begin
            if (bit_cnt_reg == `XCV_CNT_HDR_LAST)
                hdr_ready_reg <= 1'b1;
            if (bit_cnt_reg == `XCV_CNT_FRAME_LAST)
                frame_done_reg <= 1'b1; // only a full frame commits
        end
    end

    // output shifter on the falling edge: status, then the read byte
    // the held words are stable here because the main clock settles them
    // well inside half a serial period
    always_ff @(negedge sclk_i or posedge sel_b_i)
    begin
        if (sel_b_i)
        begin
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
            out_sh_reg <= 7'h00;
        end
        else
        begin
            miso_oe_o <= 1'b1;
            if (bit_cnt_reg == `XCV_CNT_ONE)
            begin
                miso_o <= status_hold_reg[6]; // seven status bits first
                out_sh_reg <= {status_hold_reg[5:0], 1'b0};
            end
            else if (bit_cnt_reg == `XCV_CNT_DATA_LOAD)
            begin
                miso_o <= rd_word_reg[7]; // then the eight data bits
                out_sh_reg <= rd_word_reg[6:0];
            end
            else
            begin
                miso_o <= out_sh_reg[6];
                out_sh_reg <= {out_sh_reg[5:0], 1'b0};
            end
        end
    end

    // crossings into the main clock
    xcv_sync2 u_sync_sel
    (
        .clk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .rst_val_i(1'b1),
        .d_i(sel_b_i),
        .q_o(sel_idle_s)
    );

    xcv_sync2 u_sync_hdr
    (
        .clk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .rst_val_i(1'b0),
        .d_i(hdr_ready_reg),
        .q_o(hdr_ready_s)
    );

    xcv_sync2 u_sync_done
    (
        .clk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .rst_val_i(1'b0),
        .d_i(frame_done_reg),
        .q_o(frame_done_s)
    );

    // edge detectors on the synchronised flags
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            hdr_ready_d_reg <= 1'b0;
            frame_done_d_reg <= 1'b0;
        end
        else
        begin
            hdr_ready_d_reg <= hdr_ready_s;
            frame_done_d_reg <= frame_done_s;
        end
    end

    assign hdr_take = hdr_ready_s & ~hdr_ready_d_reg;
    assign frame_take = frame_done_s & ~frame_done_d_reg;
    assign is_write = hdr_reg[7];
    assign cur_addr = hdr_reg[6:0];
    assign wr_hit = index_of(cur_addr) >> 4 != 5'h00;
    assign wr_idx = 4'(index_of(cur_addr));

    // status frozen while a frame is open so all seven bits agree
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
            status_hold_reg <= 7'h00;
        else if (sel_idle_s)
        begin
            status_hold_reg[`XCV_ST_LOCK] <= synth_lock_i;
            status_hold_reg[`XCV_ST_OVER] <= queue_over_i;
            status_hold_reg[`XCV_ST_UNDER] <= queue_under_i;
            status_hold_reg[`XCV_ST_FULL] <= queue_full_i;
            status_hold_reg[`XCV_ST_EMPTY] <= queue_empty_i;
            status_hold_reg[`XCV_ST_CODE_MSB:0] <= queue_state_code_i;
        end
    end

    // read word, chosen once the address byte is in; power state never gates it
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
            rd_word_reg <= 8'h00;
        else if (hdr_take)
        begin
            if (is_write)
                rd_word_reg <= 8'h00;
            else
            begin
                case (cur_addr)
                    `XCV_ADDR_SILICON_REVISION: rd_word_reg <= SILICON_ID;
                    `XCV_ADDR_QUEUE_CONTROL_STATUS:
                        rd_word_reg <= {queue_state_code_i, queue_over_i, queue_under_i,
                            queue_full_i, queue_empty_i, store_reg[`XCV_IDX_QCTL][1:0]};
                    `XCV_ADDR_QUEUE_DATA_PORT: rd_word_reg <= queue_rdata_i;
                    `XCV_ADDR_IRQ_PENDING: rd_word_reg <= {2'b00, irq_pending_i};
                    `XCV_ADDR_PIN_READBACK: rd_word_reg <= pin_readback_i;
                    `XCV_ADDR_REGULATOR_STATUS: rd_word_reg <= {4'h0, regulator_status_i};
                    default: rd_word_reg <= wr_hit ? store_reg[wr_idx] : 8'h00;
                endcase
            end
        end
    end

    // register file: a write lands once the full frame has crossed
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < `XCV_NUM_STORE; i++)
                store_reg[i] <= reset_of(4'(i));
        end
        else if (frame_take && is_write)
        begin
            if (cur_addr == `XCV_ADDR_POWER_MODE_CONTROL && dat_reg[`XCV_SOFT_RESET_BIT])
            begin
                for (int i = 0; i < `XCV_NUM_STORE; i++)
                    store_reg[i] <= reset_of(4'(i));
            end
            else if (wr_hit)
                store_reg[wr_idx] <= dat_reg & mask_of(wr_idx); // stored unchecked
        end
    end

    // strobes to the queue and the soft reset, one cycle each
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            queue_push_o <= 1'b0;
            queue_wdata_o <= 8'h00;
            queue_pop_o <= 1'b0;
            queue_cmd_stb_o <= 1'b0;
            queue_cmd_o <= 2'b00;
            soft_reset_o <= 1'b0;
        end
        else
        begin
            queue_push_o <= frame_take && is_write && cur_addr == `XCV_ADDR_QUEUE_DATA_PORT;
            queue_pop_o <= hdr_take && !is_write && cur_addr == `XCV_ADDR_QUEUE_DATA_PORT;
            queue_cmd_stb_o <= frame_take && is_write
                && cur_addr == `XCV_ADDR_QUEUE_CONTROL_STATUS;
            soft_reset_o <= frame_take && is_write
                && cur_addr == `XCV_ADDR_POWER_MODE_CONTROL && dat_reg[`XCV_SOFT_RESET_BIT];
            if (frame_take && is_write)
            begin
                queue_wdata_o <= dat_reg;
                queue_cmd_o <= dat_reg[1:0];
            end
        end
    end

    assign req_power = store_reg[`XCV_IDX_POWER][`XCV_POWER_STATE_FIELD_MSB:0];

    // effective power state; tx active cannot drop straight to sleep or standby
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
            eff_power_reg <= `XCV_DEEP_SLEEP_STATE;
        else
        begin
            case (req_power)
                `XCV_DEEP_SLEEP_STATE, `XCV_STANDBY_STATE:
                    if (eff_power_reg != `XCV_TX_ACTIVE_STATE)
                        eff_power_reg <= req_power;
                `XCV_REGULATOR_ON_STATE, `XCV_RX_SYNTH_SETTLE_STATE,
                `XCV_RX_ACTIVE_STATE, `XCV_TX_SYNTH_SETTLE_STATE, `XCV_TX_ACTIVE_STATE:
                    eff_power_reg <= req_power;
                default: eff_power_reg <= eff_power_reg; // undefined codes leave it
            endcase
        end
    end

    // configuration outputs straight from storage, except the power state, which comes from the guarded effective state
    assign power_state_o = eff_power_reg;
    assign osc_gain_o = store_reg[`XCV_IDX_OSC][3:0];
    assign irq_mask_o = store_reg[`XCV_IDX_IRQ_MASK][5:0];
    assign irq_invert_o = store_reg[`XCV_IDX_IRQ_POL][5:0];
    assign host_mode_o = store_reg[`XCV_IDX_HOST_MODE][3:0];
    assign pin_cfg_one_o = store_reg[`XCV_IDX_PIN_ONE];
    assign pin_cfg_two_o = store_reg[`XCV_IDX_PIN_TWO];
    assign modulation_o = store_reg[`XCV_IDX_MODULATION][6:0];
    assign line_coding_o = store_reg[`XCV_IDX_CODING][3:0];
    assign frame_cfg_o = store_reg[`XCV_IDX_FRAME];
    assign check_seed_o = {store_reg[`XCV_IDX_SEED3], store_reg[`XCV_IDX_SEED2],
        store_reg[`XCV_IDX_SEED1], store_reg[`XCV_IDX_SEED0]};

endmodule : xcv_spi_regs

`default_nettype wire

/* File: verification/xcv_spi_regs_asserts.sv */
/*
  Checker of the register port outputs, bound to xcv_spi_regs.
  Assumes mclk_i is the only clock that it needs for sampling.
*/
`timescale 1ns/100ps
`default_nettype none
module xcv_spi_regs_asserts
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic sel_b_i,
    input wire logic miso_o,
    input wire logic miso_oe_o,
    input wire logic [3:0] power_state_o,
    input wire logic soft_reset_o,
    input wire logic [3:0] osc_gain_o,
    input wire logic queue_cmd_stb_o,
    input wire logic queue_push_o,
    input wire logic queue_pop_o,
    input wire logic [31:0] check_seed_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // serial output parked once deselect has settled
    idle_out_a: assert property (sel_b_i [*2] |-> !miso_oe_o && !miso_o)
        else $error("serial output active while deselected");
    soft_pulse_a: assert property (soft_reset_o |=> !soft_reset_o)
        else $error("soft reset pulse too long");
    // restore must land within a few cycles of the pulse
    soft_restore_a: assert property (soft_reset_o |-> ##[0:3]
        (osc_gain_o == 4'h2 && check_seed_o == 32'hFFFFFFFF))
        else $error("soft reset did not restore config");
    tx_guard_a: assert property (power_state_o == 4'hD |=>
        power_state_o != 4'h0 && power_state_o != 4'h5)
        else $error("left tx active straight to sleep or standby");
    power_code_a: assert property (power_state_o inside
        {4'h0, 4'h4, 4'h5, 4'h8, 4'h9, 4'hC, 4'hD})
        else $error("undefined power state code");
    // no commit can come long after the frame has closed
    quiet_idle_a: assert property (sel_b_i [*8] |-> $stable(check_seed_o) && !queue_push_o)
        else $error("register change without a frame");
    push_pulse_a: assert property ($rose(queue_push_o) |=> $fell(queue_push_o))
        else $error("push pulse too long");
    pop_pulse_a: assert property (queue_pop_o |=> !queue_pop_o)
        else $error("pop pulse too long");
    cmd_pulse_a: assert property (queue_cmd_stb_o |=> !queue_cmd_stb_o)
        else $error("command strobe too long");
    cover property (soft_reset_o);
    cover property (queue_push_o);
    cover property (power_state_o == 4'hD);
endmodule : xcv_spi_regs_asserts
bind xcv_spi_regs xcv_spi_regs_asserts chk_u (.mclk_i, .rst_b_i, .sel_b_i, .miso_o,
    .miso_oe_o, .power_state_o, .soft_reset_o, .osc_gain_o, .queue_cmd_stb_o,
    .queue_push_o, .queue_pop_o, .check_seed_o);
`default_nettype wire

/* File: verification/xcv_host_model.sv */
/*
  Host serial master model, 64 ns serial clock.
  Assumes frames are started one at a time by the testbench.
*/
`timescale 1ns/100ps
`default_nettype none
module xcv_host_model
(
    output logic sclk_o,
    output logic sel_b_o,
    output logic mosi_o,
    input wire logic miso_i
);
    // clock idle low; one early select rise resets the serial side
    initial
    begin
        sclk_o = 1'b0;
        sel_b_o = 1'b0;
        mosi_o = 1'b0;
        #5;
        sel_b_o = 1'b1;
    end
    // msb first, data set while clock low, sampled on rise
    task automatic frame(input logic [15:0] word, input int nbits, output logic [14:0] rx);
        rx = '0;
        sel_b_o = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            mosi_o = word[15-i];
            #32;
            sclk_o = 1'b1;
            if (i > 0)
                rx = {rx[13:0], miso_i};
            #32;
            sclk_o = 1'b0;
        end
        #32;
        sel_b_o = 1'b1;
        mosi_o = ~mosi_o; // released line shows no stale value
        #128;
    endtask : frame
endmodule : xcv_host_model
`default_nettype wire

/* File: verification/xcv_spi_regs_tb.sv */
/*
  Self-checking testbench of the serial register port.
  Assumes the host model drives the serial pins.
*/
`timescale 1ns/100ps
`default_nettype none
module xcv_spi_regs_tb;
    localparam logic [7:0] REV_ID = 8'h3C; // arbitrary value
    logic mclk_i, rst_b_i, sclk_i, sel_b_i, mosi_i, miso_o, miso_oe_o;
    logic synth_lock_i, queue_over_i, queue_under_i, queue_full_i, queue_empty_i;
    logic [1:0] queue_state_code_i, queue_cmd_o;
    logic [7:0] queue_rdata_i, pin_readback_i, pin_cfg_one_o, pin_cfg_two_o;
    logic [7:0] queue_wdata_o, frame_cfg_o;
    logic [5:0] irq_pending_i, irq_mask_o, irq_invert_o;
    logic [3:0] regulator_status_i, power_state_o, osc_gain_o, host_mode_o, line_coding_o;
    logic [6:0] modulation_o;
    logic [31:0] check_seed_o;
    logic soft_reset_o, queue_cmd_stb_o, queue_push_o, queue_pop_o;
    logic [14:0] rx;
    int errors = 0;
    int samples_checked = 0;
    logic [15:0] pulse_cnt = '0;
    // strobe tally, a nibble each
    always @(posedge mclk_i)
        if (rst_b_i)
            pulse_cnt <= pulse_cnt + {3'h0, soft_reset_o, 3'h0, queue_cmd_stb_o,
                3'h0, queue_pop_o, 3'h0, queue_push_o};
    xcv_spi_regs #(.SILICON_ID(REV_ID)) dut_u (.mclk_i, .rst_b_i, .sclk_i, .sel_b_i,
        .mosi_i, .miso_o, .miso_oe_o, .synth_lock_i, .queue_over_i, .queue_under_i,
        .queue_full_i, .queue_empty_i, .queue_state_code_i, .queue_rdata_i,
        .irq_pending_i, .pin_readback_i, .regulator_status_i, .power_state_o,
        .soft_reset_o, .osc_gain_o, .queue_cmd_o, .queue_cmd_stb_o, .queue_push_o,
        .queue_wdata_o, .queue_pop_o, .irq_mask_o, .irq_invert_o, .host_mode_o,
        .pin_cfg_one_o, .pin_cfg_two_o, .modulation_o, .line_coding_o, .frame_cfg_o,
        .check_seed_o);
    xcv_host_model host_u (.sclk_o(sclk_i), .sel_b_o(sel_b_i), .mosi_o(mosi_i), .miso_i(miso_o));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.frame({1'b1, a, d}, 16, rx);
    endtask : wr
    // status pattern 1010110 is asymmetric so swapped bits show
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        host_u.frame({1'b0, a, 8'h00}, 16, rx);
        check(rx[14:8], 7'b1010110, "status");
        check(rx[7:0], exp, "read data");
    endtask : rd
    task automatic reset_values();
        logic [14:0] t[20] = '{{7'h00, REV_ID}, {7'h01, 8'hC5}, {7'h02, 8'h00},
            {7'h03, 8'h02}, {7'h04, 8'h97}, {7'h05, 8'h96}, {7'h06, 8'h00}, {7'h07, 8'h2B},
            {7'h08, 8'h03}, {7'h0C, 8'hF8}, {7'h0D, 8'h00}, {7'h0F, 8'h00}, {7'h10, 8'h02},
            {7'h11, 8'h02}, {7'h12, 8'h00}, {7'h14, 8'hFF}, {7'h15, 8'hFF}, {7'h16, 8'hFF},
            {7'h17, 8'hFF}, {7'h1B, 8'h09}};
        foreach (t[i])
            rd(t[i][14:8], t[i][7:0]);
        check({pin_cfg_one_o, pin_cfg_two_o, frame_cfg_o}, 24'hF80000, "pin config reset");
        check({irq_mask_o, irq_invert_o, host_mode_o, modulation_o, line_coding_o},
            27'h0001822, "config reset");
    endtask : reset_values
    task automatic store_and_refuse();
        wr(7'h01, 8'hA5);
        rd(7'h01, 8'hA5);
        wr(7'h03, 8'hFF);
        rd(7'h03, 8'h0F);
        check(osc_gain_o, 4'hF, "osc gain");
        wr(7'h14, 8'h12);
        wr(7'h15, 8'h34);
        wr(7'h16, 8'h56);
        wr(7'h17, 8'h78);
        check(check_seed_o, 32'h12345678, "seed order");
        wr(7'h00, 8'h00);
        rd(7'h00, REV_ID);
        wr(7'h0E, 8'hFF); // read-only pin port
        rd(7'h0E, 8'h5A);
        host_u.frame({1'b1, 7'h01, 8'h11}, 10, rx); // cut short
        rd(7'h01, 8'hA5);
    endtask : store_and_refuse
    task automatic power_steps();
        logic [7:0] t[13] = '{8'h55, 8'hCC, 8'hDD, 8'h0D, 8'h5D, 8'hCC, 8'h00, 8'h44,
            8'h55, 8'h88, 8'h99, 8'h00, 8'h00};
        foreach (t[i])
        begin
            wr(7'h02, {4'h0, t[i][7:4]});
            #1000; // shortened settle waits
            check(power_state_o, t[i][3:0], "power state");
        end
    endtask : power_steps
    task automatic queue_and_soft_reset();
        wr(7'h05, 8'h3C);
        check(queue_wdata_o, 8'h3C, "queue data");
        wr(7'h04, 8'h01);
        check(queue_cmd_o, 2'h1, "queue command");
        rd(7'h04, 8'h95);
        wr(7'h02, 8'h80);
        rd(7'h01, 8'hC5);
        rd(7'h02, 8'h00);
        check(check_seed_o, 32'hFFFFFFFF, "seed after soft reset");
        check(pulse_cnt, 16'h1111, "strobes");
    endtask : queue_and_soft_reset
    task automatic complete_run();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    initial
    begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    initial
    begin
        rst_b_i = 1'b0;
        {synth_lock_i, queue_over_i, queue_under_i, queue_full_i, queue_empty_i} = 5'h15;
        queue_state_code_i = 2'h2;
        queue_rdata_i = 8'h96;
        irq_pending_i = 6'h2B;
        pin_readback_i = 8'h5A;
        regulator_status_i = 4'h9;
        repeat (2) @(posedge mclk_i);
        #1 rst_b_i = 1'b1;
        repeat (4) @(posedge mclk_i);
        reset_values();
        store_and_refuse();
        power_steps();
        queue_and_soft_reset();
        complete_run();
    end
    // whole run needs about 80 us
    initial
    begin
        #300000;
        errors++;
        complete_run();
    end
endmodule : xcv_spi_regs_tb
`default_nettype wire
